// ===== logic/ers_los_detect.sv
// receive loss of signal detection from the line bit stream
`timescale 1ns/100ps
`include "ers_params.svh"
module ers_los_detect (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bit_stb,
    input wire logic bit_val,
    output logic los
);
    import ers_pkg::*;

    logic [7:0] zero_run_r;
    logic [7:0] win_pos_r;
    logic [7:0] win_ones_r;
    logic win_open_r;
    logic win_done;
    logic zeros_full;

    assign zeros_full = bit_stb && !bit_val
        && (zero_run_r == `ERS_LOS_WINDOW - 8'd1);
    assign win_done = bit_stb && win_open_r
        && (win_pos_r == `ERS_LOS_WINDOW - 8'd1);

    // run of consecutive zero bit periods
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_run_r <= 8'h00;
        end else if (bit_stb) begin
            if (bit_val) begin
                zero_run_r <= 8'h00;
            end else if (zero_run_r != `ERS_LOS_WINDOW) begin
                zero_run_r <= zero_run_r + 8'h01;
            end
        end
    end

    // density window opened only by a pulse while in loss
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_open_r <= 1'b0;
            win_pos_r <= 8'h00;
            win_ones_r <= 8'h00;
        end else if (!los || win_done) begin
            win_open_r <= 1'b0;
            win_pos_r <= 8'h00;
            win_ones_r <= 8'h00;
        end else if (bit_stb && (win_open_r || bit_val)) begin
            win_open_r <= 1'b1;
            win_pos_r <= win_pos_r + 8'h01;
            win_ones_r <= win_ones_r + {7'h00, bit_val};
        end
    end

    // set after 192 zeros, clear on 12.5% density (see R18)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            los <= 1'b0;
        end else if (zeros_full) begin
            los <= 1'b1;
        end else if (win_done
            && (win_ones_r + {7'h00, bit_val}) >= `ERS_LOS_MIN_ONES) begin
            los <= 1'b0;
        end
    end

endmodule : ers_los_detect

// ===== logic/ers_ms_timer.sv
// holds a level once a run condition has lasted a set number of cycles
`timescale 1ns/100ps
module ers_ms_timer #(
    parameter int unsigned CYCLES = 1000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic expired
);
    import ers_pkg::*;

    logic [23:0] count_r;

    // count while running, restart whenever the run condition drops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= 24'h000000;
        end else if (!run) begin
            count_r <= 24'h000000;
        end else if (count_r != CYCLES[23:0]) begin
            count_r <= count_r + 24'h000001;
        end
    end

    // level stays up until run drops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expired <= 1'b0;
        end else begin
            expired <= run && (count_r == CYCLES[23:0]);
        end
    end

endmodule : ers_ms_timer

// ===== logic/ers_params.svh
// constants for the e1 receive sync status page
`ifndef ERS_PARAMS_SVH
`define ERS_PARAMS_SVH

// page and register offsets
`define ERS_STATUS_PAGE 3'h3
`define ERS_OFF_SYNC 5'h10
`define ERS_OFF_ALARM1 5'h11
`define ERS_OFF_TIMER 5'h12
`define ERS_OFF_PHASE_HI 5'h13
`define ERS_OFF_PHASE_LO 5'h14
`define ERS_OFF_FAS 5'h15
`define ERS_OFF_SIGNAL 5'h16
`define ERS_OFF_JITTER 5'h17
`define ERS_OFF_NFAS 5'h18
`define ERS_OFF_MFAS 5'h19
`define ERS_OFF_ALARM2 5'h1b
`define ERS_OFF_IDENT 5'h1f

// sync status field positions
`define ERS_BIT_BASIC_LOST 7
`define ERS_BIT_MF_LOST 6
`define ERS_BIT_CRC4_LOST 5
`define ERS_BIT_EBIT1 4
`define ERS_BIT_EBIT2 3
`define ERS_BIT_CRC4_TO 2
`define ERS_BIT_RED 1
`define ERS_BIT_IWK 0

// other field positions
`define ERS_BIT_ALARM1_LOS 4
`define ERS_BIT_SIGNAL_LOS 5

// reset and answer values
`define ERS_RESET_BYTE 8'h00
`define ERS_RESET_SYNC 8'he0
`define ERS_IDENT_DEFAULT 8'h5a

// timing
`define ERS_CLK_KHZ 125000
`define ERS_CRC4_TIMEOUT_MS 8
`define ERS_RED_DELAY_MS 100
`define ERS_LOS_WINDOW 8'd192
`define ERS_LOS_MIN_ONES 8'd24

`endif

// ===== logic/ers_pkg.sv
// types shared by the e1 receive sync status page
package ers_pkg;

    // framing state reported by the receive framer
    typedef struct packed {
        logic basic_lost;
        logic multiframe_align_lost;
        logic crc4_multiframe_lost;
        logic crc4_interwork_state;
        logic mf_end;
        logic rx_ebit_first;
        logic rx_ebit_second;
    } ers_frame_state_t;

    // raw status words captured from the receive path
    typedef struct packed {
        logic [7:0] alarm_one;
        logic [7:0] timer;
        logic rx_slip_toggle;
        logic rx_slip_direction;
        logic [5:0] phase_flags;
        logic [4:0] rx_timeslot_count;
        logic [2:0] rx_bit_count;
        logic [7:0] fas;
        logic [4:0] equalizer_state;
        logic [7:0] jitter;
        logic [7:0] nfas;
        logic [7:0] mfas;
        logic [7:0] alarm_two;
    } ers_rx_words_t;

    // crc-4 multiframe search progress
    typedef enum logic [3:0] {
        ERS_WAIT_BASIC = 4'h1,
        ERS_SEARCH = 4'h2,
        ERS_ALIGNED = 4'h4,
        ERS_TIMED_OUT = 4'h8
    } ers_crc4_state_t;

endpackage : ers_pkg

// ===== logic/ers_sync_status.sv
// e1 receive synchronization status page with parallel read port
//
// Functional notes
// R1 - bit 7 shows basic frame alignment lost
// R2 - bit 6 shows multiframe alignment lost
// R3 - bit 5 shows crc-4 multiframe alignment lost
// R4 - bit 4 holds first e-bit of multiframe
// R5 - bit 3 holds second e-bit of multiframe
// R6 - bit 2 sets on 8 ms crc-4 timeout
// R7 - timeout forces reframe under maintenance, no interworking
// R8 - bit 1 red after 100 ms loss
// R9 - bit 0 shows crc-4 interworking result
// R10 - address 11h holds alarm status word
// R11 - address 13h holds slip and phase flags
// R12 - address 14h holds timeslot and bit count
// R13 - address 15h holds received fas byte
// R14 - address 16h holds equalizer and line loss
// R15 - address 17h holds jitter buffer conditions
// R16 - address 18h holds received nfas byte
// R17 - address 19h holds received mfas bits
// R18 - loss of signal after 192 zeros
// R19 - all registers read-only, reads change nothing
// R20 - unused addresses read zero, ignore writes
`timescale 1ns/100ps
`include "ers_params.svh"
module ers_sync_status #(
    parameter int unsigned CRC4_TO_CYCLES =
        `ERS_CRC4_TIMEOUT_MS * `ERS_CLK_KHZ,
    parameter int unsigned RED_CYCLES =
        `ERS_RED_DELAY_MS * `ERS_CLK_KHZ,
    parameter logic [7:0] IDENT_VALUE = `ERS_IDENT_DEFAULT
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] page,
    input wire logic [4:0] addr,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire ers_pkg::ers_frame_state_t frame_in,
    input wire ers_pkg::ers_rx_words_t rx_in,
    input wire logic bit_stb,
    input wire logic bit_val,
    input wire logic maint_opt_en,
    input wire logic auto_interwork_en,
    output logic force_reframe,
    output logic line_signal_loss
);
    import ers_pkg::*;

    // true when the port addresses a given offset of the status page
    function automatic logic ers_hit(input logic [2:0] pg,
                                     input logic [4:0] a,
                                     input logic [4:0] off);
        ers_hit = (pg == `ERS_STATUS_PAGE) && (a == off);
    endfunction : ers_hit

    logic rst_meta_r;
    logic rst_n;
    ers_crc4_state_t crc4_state_r;
    ers_crc4_state_t crc4_state_nxt;
    logic [7:0] sync_r;
    logic [7:0] alarm1_r;
    logic [7:0] timer_r;
    logic [7:0] phase_hi_r;
    logic [7:0] phase_lo_r;
    logic [7:0] fas_r;
    logic [7:0] signal_r;
    logic [7:0] jitter_r;
    logic [7:0] nfas_r;
    logic [7:0] mfas_r;
    logic [7:0] alarm2_r;
    logic ebit1_r;
    logic ebit2_r;
    logic crc4_to_r;
    logic reframe_r;
    logic timeout_hit;
    logic red_level;
    logic los_level;
    logic rd_req;
    logic [7:0] rd_mux;
    logic write_seen;

    // reset release through two flip-flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // crc-4 search runs from basic alignment, or from a loss of crc-4 alignment, until crc-4 alignment
    always_comb begin
        crc4_state_nxt = crc4_state_r;
        case (crc4_state_r)
            ERS_WAIT_BASIC: begin
                if (!frame_in.basic_lost) begin
                    crc4_state_nxt = ERS_SEARCH;
                end
            end
            ERS_SEARCH: begin
                if (frame_in.basic_lost) begin
                    crc4_state_nxt = ERS_WAIT_BASIC;
                end else if (!frame_in.crc4_multiframe_lost) begin
                    crc4_state_nxt = ERS_ALIGNED;
                end else if (timeout_hit) begin
                    crc4_state_nxt = ERS_TIMED_OUT;
                end
            end
            ERS_ALIGNED: begin
                if (frame_in.basic_lost) begin
                    crc4_state_nxt = ERS_WAIT_BASIC;
                end else if (frame_in.crc4_multiframe_lost) begin
                    crc4_state_nxt = ERS_SEARCH;
                end
            end
            ERS_TIMED_OUT: begin
                if (frame_in.basic_lost) begin
                    crc4_state_nxt = ERS_WAIT_BASIC;
                end else if (!frame_in.crc4_multiframe_lost) begin
                    crc4_state_nxt = ERS_ALIGNED;
                end
            end
            default: begin
                crc4_state_nxt = ERS_WAIT_BASIC;
            end
        endcase
    end

    // search state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc4_state_r <= ERS_WAIT_BASIC;
        end else begin
            crc4_state_r <= crc4_state_nxt;
        end
    end

    // 8 ms window counted from basic alignment or from a loss of crc-4 alignment
    ers_ms_timer #(
        .CYCLES(CRC4_TO_CYCLES)
    ) u_crc4_timer (
        .clk(clk),
        .rst_n(rst_n),
        .run(crc4_state_r == ERS_SEARCH),
        .expired(timeout_hit)
    );

    // 100 ms of continuous basic frame loss
    ers_ms_timer #(
        .CYCLES(RED_CYCLES)
    ) u_red_timer (
        .clk(clk),
        .rst_n(rst_n),
        .run(frame_in.basic_lost),
        .expired(red_level)
    );

    // line loss of signal from the raw bit stream
    ers_los_detect u_los (
        .clk(clk),
        .rst_n(rst_n),
        .bit_stb(bit_stb),
        .bit_val(bit_val),
        .los(los_level)
    );

    // timeout flag follows the timed out search state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc4_to_r <= 1'b0;
        end else begin
            crc4_to_r <= (crc4_state_nxt == ERS_TIMED_OUT); // see R6
        end
    end

    // one pulse on the flag's rising edge, gated by the options
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reframe_r <= 1'b0;
        end else begin
            reframe_r <= (crc4_state_nxt == ERS_TIMED_OUT) && !crc4_to_r
                && maint_opt_en && !auto_interwork_en; // see R7
        end
    end

    assign force_reframe = reframe_r;
    assign line_signal_loss = los_level;

    // e-bits latched at the end of each crc-4 multiframe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ebit1_r <= 1'b0;
            ebit2_r <= 1'b0;
        end else if (frame_in.mf_end) begin
            ebit1_r <= frame_in.rx_ebit_first; // see R4
            ebit2_r <= frame_in.rx_ebit_second; // see R5
        end
    end

    // synchronization status word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_r <= `ERS_RESET_SYNC;
        end else begin
            sync_r[`ERS_BIT_BASIC_LOST] <= frame_in.basic_lost; // see R1
            sync_r[`ERS_BIT_MF_LOST] <=
                frame_in.multiframe_align_lost; // see R2
            sync_r[`ERS_BIT_CRC4_LOST] <=
                frame_in.crc4_multiframe_lost; // see R3
            sync_r[`ERS_BIT_EBIT1] <= ebit1_r; // see R4
            sync_r[`ERS_BIT_EBIT2] <= ebit2_r; // see R5
            sync_r[`ERS_BIT_CRC4_TO] <= crc4_to_r; // see R6
            // red drops in the cycle basic alignment returns
            sync_r[`ERS_BIT_RED] <= red_level
                && frame_in.basic_lost; // see R8
            sync_r[`ERS_BIT_IWK] <=
                frame_in.crc4_interwork_state; // see R9
        end
    end

    // alarm status word one, loss bit from the local detector
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm1_r <= `ERS_RESET_BYTE;
        end else begin
            alarm1_r <= rx_in.alarm_one; // see R10
            alarm1_r[`ERS_BIT_ALARM1_LOS] <= los_level; // see R18
        end
    end

    // timer status and alarm status word two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_r <= `ERS_RESET_BYTE;
            alarm2_r <= `ERS_RESET_BYTE;
        end else begin
            timer_r <= rx_in.timer;
            alarm2_r <= rx_in.alarm_two;
        end
    end

    // phase status words
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_hi_r <= `ERS_RESET_BYTE;
            phase_lo_r <= `ERS_RESET_BYTE;
        end else begin
            phase_hi_r <= {rx_in.rx_slip_toggle, rx_in.rx_slip_direction,
                rx_in.phase_flags}; // see R11
            phase_lo_r <= {rx_in.rx_timeslot_count,
                rx_in.rx_bit_count}; // see R12
        end
    end

    // received alignment bytes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fas_r <= `ERS_RESET_BYTE;
            nfas_r <= `ERS_RESET_BYTE;
            mfas_r <= `ERS_RESET_BYTE;
        end else begin
            fas_r <= rx_in.fas; // see R13
            nfas_r <= rx_in.nfas; // see R16
            mfas_r <= rx_in.mfas; // see R17
        end
    end

    // line signal and jitter buffer status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            signal_r <= `ERS_RESET_BYTE;
            jitter_r <= `ERS_RESET_BYTE;
        end else begin
            signal_r <= {3'h0, rx_in.equalizer_state}; // see R14
            signal_r[`ERS_BIT_SIGNAL_LOS] <= los_level; // see R14
            jitter_r <= rx_in.jitter; // see R15
        end
    end

    // a read cycle on the status page
    assign rd_req = !cs_n && !rd_n && (page == `ERS_STATUS_PAGE);
    // writes are decoded only to be dropped
    assign write_seen = !cs_n && !wr_n && (data_in == data_in);

    // read selection, unused offsets answer zero
    always_comb begin
        rd_mux = `ERS_RESET_BYTE; // see R20
        if (ers_hit(page, addr, `ERS_OFF_SYNC)) begin
            rd_mux = sync_r;
        end else if (ers_hit(page, addr, `ERS_OFF_ALARM1)) begin
            rd_mux = alarm1_r;
        end else if (ers_hit(page, addr, `ERS_OFF_TIMER)) begin
            rd_mux = timer_r;
        end else if (ers_hit(page, addr, `ERS_OFF_PHASE_HI)) begin
            rd_mux = phase_hi_r;
        end else if (ers_hit(page, addr, `ERS_OFF_PHASE_LO)) begin
            rd_mux = phase_lo_r;
        end else if (ers_hit(page, addr, `ERS_OFF_FAS)) begin
            rd_mux = fas_r;
        end else if (ers_hit(page, addr, `ERS_OFF_SIGNAL)) begin
            rd_mux = signal_r;
        end else if (ers_hit(page, addr, `ERS_OFF_JITTER)) begin
            rd_mux = jitter_r;
        end else if (ers_hit(page, addr, `ERS_OFF_NFAS)) begin
            rd_mux = nfas_r;
        end else if (ers_hit(page, addr, `ERS_OFF_MFAS)) begin
            rd_mux = mfas_r;
        end else if (ers_hit(page, addr, `ERS_OFF_ALARM2)) begin
            rd_mux = alarm2_r;
        end else if (ers_hit(page, addr, `ERS_OFF_IDENT)) begin
            rd_mux = IDENT_VALUE; // arbitrary neutral identity value
        end
    end

    // read data held in a register; a read never touches status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= `ERS_RESET_BYTE;
        end else if (rd_req && !write_seen) begin
            data_out <= rd_mux; // see R19
        end
    end

    // bus driven one cycle after the strobe, while it lasts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_oe <= 1'b0;
        end else begin
            data_oe <= rd_req && !write_seen; // see R19
        end
    end

endmodule : ers_sync_status

// ===== tb/ers_host_model.sv
// host processor model driving the parallel register port
`timescale 1ns/100ps
module ers_host_model (
    input wire logic clk,
    output logic [2:0] page,
    output logic [4:0] addr,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] data_in
);
    // idle bus from time zero
    initial begin
        page = 3'h3;
        addr = 5'h00;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        data_in = 8'h00;
    end

    // one byte cycle, held across the taking edge
    task automatic access(input logic [2:0] pg, input logic [4:0] a,
                          input logic wr, input logic [7:0] d);
        @(negedge clk);
        page = pg;
        addr = a;
        data_in = wr ? d : ~data_in;
        cs_n = 1'b0;
        rd_n = wr;
        wr_n = !wr;
        @(negedge clk);
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        data_in = ~data_in; // released data does not keep its value
    endtask : access
endmodule : ers_host_model

// ===== tb/ers_sync_status_assertions.sv
// port-level checks for the sync status page
`timescale 1ns/100ps
module ers_sync_status_chk
    import ers_pkg::*;
#(
    parameter int unsigned CRC4_TO_CYCLES = 50,
    parameter int unsigned RED_CYCLES = 80,
    parameter logic [7:0] IDENT_VALUE = 8'h00
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] page,
    input wire logic [4:0] addr,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire ers_pkg::ers_frame_state_t frame_in,
    input wire ers_pkg::ers_rx_words_t rx_in,
    input wire logic bit_stb,
    input wire logic bit_val,
    input wire logic maint_opt_en,
    input wire logic auto_interwork_en,
    input wire logic force_reframe,
    input wire logic line_signal_loss
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // a read taken on the status page
    sequence s_rd_any;
        !cs_n && !rd_n && wr_n && page == 3'h3;
    endsequence
    sequence s_rd(logic [4:0] a);
        !cs_n && !rd_n && wr_n && page == 3'h3 && addr == a;
    endsequence
    sequence s_rd_unused;
        s_rd_any ##0 (addr == 5'h1a || (addr >= 5'h1c && addr <= 5'h1e));
    endsequence

    property p_oe_on_read;
        s_rd_any |=> data_oe;
    endproperty
    a_oe_on_read: assert property (p_oe_on_read)
        else $error("read not answered");
    property p_oe_idle;
        !(!cs_n && !rd_n && wr_n && page == 3'h3) |=> !data_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("bus driven without a read");
    property p_hold;
        !(!cs_n && !rd_n && wr_n && page == 3'h3) |=> $stable(data_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data changed without a read");
    property p_unused;
        s_rd_unused |=> data_out == 8'h00;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused address not zero");
    property p_phase_lo;
        s_rd(5'h14) |=> data_out == {$past(rx_in.rx_timeslot_count, 2),
            $past(rx_in.rx_bit_count, 2)};
    endproperty
    a_phase_lo: assert property (p_phase_lo)
        else $error("phase low word wrong");
    property p_phase_hi;
        s_rd(5'h13) |=> data_out == {$past(rx_in.rx_slip_toggle, 2),
            $past(rx_in.rx_slip_direction, 2), $past(rx_in.phase_flags, 2)};
    endproperty
    a_phase_hi: assert property (p_phase_hi)
        else $error("phase high word wrong");
    property p_sync;
        s_rd(5'h10) |=> {data_out[7:5], data_out[0]} ==
            {$past(frame_in.basic_lost, 2),
            $past(frame_in.multiframe_align_lost, 2),
            $past(frame_in.crc4_multiframe_lost, 2),
            $past(frame_in.crc4_interwork_state, 2)};
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync level bits wrong");
    property p_reframe_gate;
        force_reframe |-> maint_opt_en && !auto_interwork_en;
    endproperty
    a_reframe_gate: assert property (p_reframe_gate)
        else $error("reframe forced while not allowed");
    property p_reframe_pulse;
        force_reframe |=> !force_reframe;
    endproperty
    a_reframe_pulse: assert property (p_reframe_pulse)
        else $error("reframe pulse too long");
    property p_los_quiet;
        !$past(bit_stb) && !bit_stb |=> $stable(line_signal_loss);
    endproperty
    a_los_quiet: assert property (p_los_quiet)
        else $error("signal loss changed without line bits");
endmodule : ers_sync_status_chk

bind ers_sync_status ers_sync_status_chk #(
    .CRC4_TO_CYCLES(CRC4_TO_CYCLES),
    .RED_CYCLES(RED_CYCLES),
    .IDENT_VALUE(IDENT_VALUE)
) u_chk (
    .clk(clk), .nrst(nrst), .page(page), .addr(addr), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .frame_in(frame_in), .rx_in(rx_in),
    .bit_stb(bit_stb), .bit_val(bit_val), .maint_opt_en(maint_opt_en),
    .auto_interwork_en(auto_interwork_en), .force_reframe(force_reframe),
    .line_signal_loss(line_signal_loss)
);

// ===== tb/tb_e1_receive_sync_status_bank.sv
// self-checking bench for the sync status page
`timescale 1ns/100ps
module tb_e1_receive_sync_status_bank;
    import ers_pkg::*;
    localparam int unsigned TO_CYC = 50;
    localparam int unsigned RED_CYC = 80;
    localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
    logic clk, nrst, bit_stb, bit_val, maint, auto_iw;
    logic [2:0] page;
    logic [4:0] addr, a;
    logic cs_n, rd_n, wr_n, data_oe, force_reframe, line_signal_loss;
    logic [7:0] data_in, data_out;
    logic [31:0] seed = 32'd44;
    logic [95:0] r;
    ers_frame_state_t fr;
    ers_rx_words_t rx;
    logic [7:0] exp_q[$];
    int err_total = 0, n_tests = 0, n_reframe = 0;

    ers_host_model u_host (.clk(clk), .page(page), .addr(addr),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in));
    ers_sync_status #(.CRC4_TO_CYCLES(TO_CYC), .RED_CYCLES(RED_CYC),
        .IDENT_VALUE(ID_VAL)) u_dut (.clk(clk), .nrst(nrst), .page(page),
        .addr(addr), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .frame_in(fr), .rx_in(rx), .bit_stb(bit_stb), .bit_val(bit_val),
        .maint_opt_en(maint), .auto_interwork_en(auto_iw),
        .force_reframe(force_reframe),
        .line_signal_loss(line_signal_loss));

    // 125 mhz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // expected byte of a status address
    function automatic logic [7:0] exp_reg(input logic [4:0] ad,
                                           input logic los);
        case (ad)
            5'h11: return {rx.alarm_one[7:5], los, rx.alarm_one[3:0]};
            5'h12: return rx.timer;
            5'h13: return {rx.rx_slip_toggle, rx.rx_slip_direction,
                           rx.phase_flags};
            5'h14: return {rx.rx_timeslot_count, rx.rx_bit_count};
            5'h15: return rx.fas;
            5'h16: return {2'b00, los, rx.equalizer_state};
            5'h17: return rx.jitter;
            5'h18: return rx.nfas;
            5'h19: return rx.mfas;
            5'h1b: return rx.alarm_two;
            5'h1f: return ID_VAL;
            default: return 8'h00;
        endcase
    endfunction : exp_reg

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [4:0] ad, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.access(3'h3, ad, 1'b0, 8'h00);
    endtask : rd

    task automatic send_bit(input logic v);
        @(negedge clk);
        bit_stb = 1'b1;
        bit_val = v;
        @(negedge clk);
        bit_stb = 1'b0;
        bit_val = ~v;
    endtask : send_bit

    task automatic end_sim();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // read data monitor and reframe pulse counter
    always @(negedge clk) begin
        if (data_oe === 1'b1) begin
            if (exp_q.size() == 0) begin
                err_total++;
                $display("BAD t=%0t got %h exp none", $time, data_out);
            end else begin
                chk(data_out, exp_q.pop_front());
            end
        end
        if (force_reframe === 1'b1) n_reframe++;
    end

    // hang guard
    initial begin
        repeat (20000) @(negedge clk);
        err_total++;
        end_sim();
    end

    // main sequence
    initial begin
        nrst = 1'b0;
        fr = 7'b1110000;
        rx = '0;
        bit_stb = 1'b0;
        bit_val = 1'b0;
        maint = 1'b1;
        auto_iw = 1'b0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        r = {xs(), xs(), xs()};
        rx = r[$bits(rx)-1:0];
        repeat (3) @(negedge clk);
        rd(5'h10, 8'he0);
        // write each address from 11h to 1fh, then read it back unchanged
        for (a = 5'h11; a != 5'h00; a++) begin
            u_host.access(3'h3, a, 1'b1, 8'(xs()));
            rd(a, exp_reg(a, 1'b0));
        end
        u_host.access(3'h2, 5'h11, 1'b0, 8'h00); // other page stays silent
        repeat (RED_CYC) @(negedge clk);
        rd(5'h10, 8'he2);
        fr.basic_lost = 1'b0;
        repeat (3) @(negedge clk);
        rd(5'h10, 8'h60);
        repeat (TO_CYC) @(negedge clk);
        rd(5'h10, 8'h64);
        chk(8'(n_reframe), 8'h01);
        // interworking on, then maintenance off: no further reframe
        for (int k = 0; k < 2; k++) begin
            maint = !k[0];
            auto_iw = maint;
            fr.basic_lost = 1'b1;
            repeat (3) @(negedge clk);
            fr.basic_lost = 1'b0;
            repeat (TO_CYC + 10) @(negedge clk);
            rd(5'h10, 8'h64);
            chk(8'(n_reframe), 8'h01);
        end
        // aligned, e-bits taken at multiframe end only
        fr = 7'b0001110;
        @(negedge clk);
        fr.mf_end = 1'b0;
        fr.rx_ebit_first = 1'b0;
        repeat (3) @(negedge clk);
        rd(5'h10, 8'h11);
        fr = 7'b0001101;
        @(negedge clk);
        fr.mf_end = 1'b0;
        fr.rx_ebit_second = 1'b0;
        repeat (3) @(negedge clk);
        rd(5'h10, 8'h09);
        // loss of signal boundary and recovery
        repeat (191) send_bit(1'b0);
        repeat (2) @(negedge clk);
        chk(8'(line_signal_loss), 8'h00);
        send_bit(1'b0);
        repeat (2) @(negedge clk);
        chk(8'(line_signal_loss), 8'h01);
        rd(5'h16, exp_reg(5'h16, 1'b1));
        rd(5'h11, exp_reg(5'h11, 1'b1));
        for (int i = 0; i < 192; i++) send_bit(i % 8 == 0);
        repeat (3) @(negedge clk);
        chk(8'(line_signal_loss), 8'h00);
        for (int i = 0; i < 10 && exp_q.size() != 0; i++) @(negedge clk);
        if (exp_q.size() != 0) err_total++;
        end_sim();
    end
endmodule : tb_e1_receive_sync_status_bank
